/* rtl/seep_prog.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------------
// What this block does
// - write frame starts self-timed word store at deselect
// - internal cycle runs without serial clock
// - busy status driven while selected mid-cycle
// - write stores word in a single overwrite, no separate clear
// - erase frame starts self-timed word clear
// - erased word reads all ones
// - enable latch cleared at power-up
// - enable command required before programming
// - enable latch holds until disable or reset
// - latch clear refuses all program commands
// - reads ignore the enable latch
// - erase-all clears every word to ones
// - write-all stores word everywhere, no clear
// - deselect only in the bit after data
// - reset gives read-only state
// - busy drives output low, ready high
// - internal cycle ends within five ms
// ---------------------------------------------------------------------
module seep_prog #(
  parameter int PROG_CYCLES = seep_pkg::PROG_CYCLE_CYCLES,
  parameter int WORDS       = 1 << seep_pkg::ADDR_W
) (
  sys_clk,
  rst_b,
  serial_clock_in,
  chip_sel,
  serial_in,
  serial_out,
  serial_out_oe,
  busy,
  prog_enabled,
  rd_addr,
  rd_data
);
  input  wire logic                         sys_clk;
  input  wire logic                         rst_b;
  input  wire logic                         serial_clock_in;
  input  wire logic                         chip_sel;
  input  wire logic                         serial_in;
  output logic                              serial_out;
  output logic                              serial_out_oe;
  output logic                              busy;
  output logic                              prog_enabled;
  input  wire logic [seep_pkg::ADDR_W-1:0]  rd_addr;
  output logic [seep_pkg::DATA_W-1:0]       rd_data;

  // ---------------------------------------------------------------------
  // link domain
  // ---------------------------------------------------------------------
  logic [seep_pkg::FRAME_BITS-1:0] lnk_frame;
  logic [5:0]                      lnk_cnt;
  logic                            cs_lvl_ff;

  // shifter held clear until the synced select is high: no stale count
  // from the last frame survives, but the host owes a select setup time
  seep_link u_link (
    .serial_clock_in (serial_clock_in),
    .link_rst_b      (cs_lvl_ff),
    .chip_sel        (chip_sel),
    .serial_in       (serial_in),
    .frame_bits      (lnk_frame),
    .bit_cnt         (lnk_cnt)
  );

  // ---------------------------------------------------------------------
  // crossings: select pin on three flops; frame words held stable while
  // the select stays low, sampled only after the settled deselect edge
  // ---------------------------------------------------------------------
  logic [2:0]                      cs_sync_ff;
  logic [2:0]                      nxt_cs_sync;
  logic                            nxt_cs_lvl;
  logic [seep_pkg::FRAME_BITS-1:0] frm_ff;
  logic [seep_pkg::FRAME_BITS-1:0] nxt_frm;
  logic [5:0]                      cnt_ff;
  logic [5:0]                      nxt_cnt;
  logic                            cs_fall;

  always_comb begin
    nxt_cs_sync = {cs_sync_ff[1:0], chip_sel};
    nxt_cs_lvl  = cs_lvl_ff;
    if (cs_sync_ff[1] == cs_sync_ff[2]) begin
      nxt_cs_lvl = cs_sync_ff[2];
    end
    cs_fall = cs_lvl_ff && !nxt_cs_lvl;
    // link shift registers are quiet once select is seen low
    nxt_frm = cs_fall ? lnk_frame : frm_ff;
    nxt_cnt = cs_fall ? lnk_cnt : cnt_ff;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_sync_ff <= 3'h0;
      cs_lvl_ff  <= 1'b0;
      frm_ff     <= '0;
      cnt_ff     <= 6'h0;
    end else begin
      cs_sync_ff <= nxt_cs_sync;
      cs_lvl_ff  <= nxt_cs_lvl;
      frm_ff     <= nxt_frm;
      cnt_ff     <= nxt_cnt;
    end
  end

  // ---------------------------------------------------------------------
  // frame decode, one cycle after the deselect
  // ---------------------------------------------------------------------
  logic                            dec_ff;
  logic                            nxt_dec;
  logic [1:0]                      opc;
  logic [1:0]                      sub;
  logic [seep_pkg::ADDR_W-1:0]     f_addr;
  logic [seep_pkg::DATA_W-1:0]     f_data;
  logic                            hdr_only;
  logic                            full_frame;

  assign nxt_dec = cs_fall;

  always_comb begin
    full_frame = (cnt_ff == 6'(seep_pkg::FRAME_BITS));
    hdr_only   = (cnt_ff == 6'(seep_pkg::HDR_BITS));
    if (full_frame) begin
      opc    = frm_ff[seep_pkg::FRAME_BITS-2 -: 2];
      f_addr = frm_ff[seep_pkg::DATA_W +: seep_pkg::ADDR_W];
      f_data = frm_ff[seep_pkg::DATA_W-1:0];
    end else begin
      opc    = frm_ff[seep_pkg::HDR_BITS-2 -: 2];
      f_addr = frm_ff[seep_pkg::ADDR_W-1:0];
      f_data = '0;
    end
    sub = f_addr[seep_pkg::SUB_HI:seep_pkg::SUB_LO];
  end

  // ---------------------------------------------------------------------
  // enable latch, command launch and self-timed cycle
  // ---------------------------------------------------------------------
  seep_pkg::seep_op_t              op_ff;
  seep_pkg::seep_op_t              nxt_op;
  seep_pkg::seep_op_t              req_op;
  logic                            prog_frm;
  logic                            en_ff;
  logic                            nxt_en;
  logic [31:0]                     tmr_ff;
  logic [31:0]                     nxt_tmr;
  logic [seep_pkg::ADDR_W-1:0]     op_addr_ff;
  logic [seep_pkg::ADDR_W-1:0]     nxt_op_addr;
  logic [seep_pkg::DATA_W-1:0]     op_data_ff;
  logic [seep_pkg::DATA_W-1:0]     nxt_op_data;
  logic [seep_pkg::ADDR_W-1:0]     sweep_ff;
  logic [seep_pkg::ADDR_W-1:0]     nxt_sweep;

  always_comb begin
    req_op = seep_pkg::SEEP_NONE;
    nxt_en = en_ff;
    // bad lengths never program: deselect off the exact bit is dropped
    if (dec_ff && hdr_only) begin
      unique case (opc)
        seep_pkg::OPC_ERASE: req_op = seep_pkg::SEEP_ERASE;
        seep_pkg::OPC_EXT: begin
          unique case (sub)
            seep_pkg::SUB_EN:   nxt_en = 1'b1;
            seep_pkg::SUB_DIS:  nxt_en = 1'b0;
            seep_pkg::SUB_EALL: req_op = seep_pkg::SEEP_EALL;
            seep_pkg::SUB_WALL: req_op = seep_pkg::SEEP_NONE;
          endcase
        end
        seep_pkg::OPC_WRITE,
        seep_pkg::OPC_READ: req_op = seep_pkg::SEEP_NONE;
      endcase
    end else if (dec_ff && full_frame) begin
      if (opc == seep_pkg::OPC_WRITE) begin
        req_op = seep_pkg::SEEP_WRITE;
      end else if (opc == seep_pkg::OPC_EXT
                   && sub == seep_pkg::SUB_WALL) begin
        req_op = seep_pkg::SEEP_WALL;
      end
    end
    // program frame seen, whether or not the latch lets it run
    prog_frm = (req_op != seep_pkg::SEEP_NONE);
    // disabled: frame taken, no cycle, status stays ready
    if (!en_ff) begin
      req_op = seep_pkg::SEEP_NONE;
    end
    // latch frozen while a cycle runs
    if (op_ff != seep_pkg::SEEP_NONE) begin
      nxt_en = en_ff;
    end

    nxt_op      = op_ff;
    nxt_tmr     = tmr_ff;
    nxt_op_addr = op_addr_ff;
    nxt_op_data = op_data_ff;
    nxt_sweep   = sweep_ff;
    // no serial clock used here: runs purely on sys_clk
    if (op_ff == seep_pkg::SEEP_NONE) begin
      if (req_op != seep_pkg::SEEP_NONE) begin
        nxt_op      = req_op;
        nxt_tmr     = 32'(PROG_CYCLES - 1);
        nxt_op_addr = f_addr;
        nxt_op_data = f_data;
        nxt_sweep   = '0;
      end
    end else begin
      nxt_sweep = sweep_ff + 1'b1;
      if (tmr_ff == 32'h0) begin
        nxt_op = seep_pkg::SEEP_NONE;
      end else begin
        nxt_tmr = tmr_ff - 32'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dec_ff     <= 1'b0;
      op_ff      <= seep_pkg::SEEP_NONE;
      en_ff      <= 1'b0;
      tmr_ff     <= 32'h0;
      op_addr_ff <= '0;
      op_data_ff <= '0;
      sweep_ff   <= '0;
    end else begin
      dec_ff     <= nxt_dec;
      op_ff      <= nxt_op;
      en_ff      <= nxt_en;
      tmr_ff     <= nxt_tmr;
      op_addr_ff <= nxt_op_addr;
      op_data_ff <= nxt_op_data;
      sweep_ff   <= nxt_sweep;
    end
  end

  // ---------------------------------------------------------------------
  // array: word ops written once, bulk ops sweep one word per cycle
  // ---------------------------------------------------------------------
  logic [seep_pkg::DATA_W-1:0] mem [WORDS];
  logic                        mem_we;
  logic [seep_pkg::ADDR_W-1:0] mem_wa;
  logic [seep_pkg::DATA_W-1:0] mem_wd;
  logic                        first_cyc;

  // bulk ops touch each word once, in the first WORDS cycles;
  // limitation: the cycle must outlast WORDS clocks
  function automatic logic sweep_live(input logic [31:0] tmr);
    return tmr >= 32'(PROG_CYCLES - WORDS);
  endfunction

  always_comb begin
    first_cyc = (tmr_ff == 32'(PROG_CYCLES - 1));
    mem_we    = 1'b0;
    mem_wa    = op_addr_ff;
    mem_wd    = seep_pkg::ERASED_WORD;
    unique case (op_ff)
      seep_pkg::SEEP_NONE: mem_we = 1'b0;
      // clear then store folds into a single overwrite
      seep_pkg::SEEP_WRITE: begin
        mem_we = first_cyc;
        mem_wd = op_data_ff;
      end
      seep_pkg::SEEP_ERASE: mem_we = first_cyc;
      seep_pkg::SEEP_EALL: begin
        mem_we = sweep_live(tmr_ff);
        mem_wa = sweep_ff;
      end
      seep_pkg::SEEP_WALL: begin
        mem_we = sweep_live(tmr_ff);
        mem_wa = sweep_ff;
        mem_wd = op_data_ff;
      end
    endcase
  end

  // array has no reset: content is nonvolatile
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // ---------------------------------------------------------------------
  // outputs: status on the data pin while selected
  // ---------------------------------------------------------------------
  logic                        nxt_so;
  logic                        nxt_so_oe;
  logic [seep_pkg::DATA_W-1:0] nxt_rd;
  logic                        poll_ff;
  logic                        nxt_poll;

  always_comb begin
    // status armed by a program frame until a deselect finds it idle
    nxt_poll = poll_ff;
    if (cs_fall && op_ff == seep_pkg::SEEP_NONE) begin
      nxt_poll = 1'b0;
    end
    if (prog_frm) begin
      nxt_poll = 1'b1;
    end
    nxt_so    = (op_ff == seep_pkg::SEEP_NONE);
    nxt_so_oe = cs_lvl_ff && (op_ff != seep_pkg::SEEP_NONE
                || poll_ff);
    // read port never looks at the enable latch
    nxt_rd    = mem[rd_addr];
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      serial_out    <= 1'b1;
      serial_out_oe <= 1'b0;
      poll_ff       <= 1'b0;
      busy          <= 1'b0;
      prog_enabled  <= 1'b0;
      rd_data       <= '0;
    end else begin
      serial_out    <= nxt_so;
      serial_out_oe <= nxt_so_oe;
      poll_ff       <= nxt_poll;
      busy          <= (nxt_op != seep_pkg::SEEP_NONE);
      prog_enabled  <= nxt_en;
      rd_data       <= nxt_rd;
    end
  end
endmodule

/* rtl/seep_pkg.sv */
package seep_pkg;
  // ---------------------------------------------------------------------
  // frame layout (x16 organisation)
  // ---------------------------------------------------------------------
  localparam int ADDR_W      = 10;
  localparam int DATA_W      = 16;
  localparam int OPC_W       = 2;
  localparam int HDR_BITS    = 1 + OPC_W + ADDR_W;
  localparam int FRAME_BITS  = HDR_BITS + DATA_W;
  localparam int SUB_HI      = ADDR_W - 1;
  localparam int SUB_LO      = ADDR_W - 2;

  localparam logic [1:0] OPC_EXT   = 2'h0;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_READ  = 2'h2;
  localparam logic [1:0] OPC_ERASE = 2'h3;
  localparam logic [1:0] SUB_DIS   = 2'h0;
  localparam logic [1:0] SUB_WALL  = 2'h1;
  localparam logic [1:0] SUB_EALL  = 2'h2;
  localparam logic [1:0] SUB_EN    = 2'h3;

  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam int CLK_MHZ           = 100;
  localparam int PROG_CYCLE_MS     = 5;
  localparam int PROG_CYCLE_CYCLES = PROG_CYCLE_MS * 1000 * CLK_MHZ;

  typedef enum logic [2:0] {
    SEEP_NONE, SEEP_WRITE, SEEP_ERASE, SEEP_EALL, SEEP_WALL
  } seep_op_t;
endpackage

/* rtl/seep_link.sv */
`timescale 1ns/10ps
// link-side shifter, clocked by the serial clock; frame and bit count leave as shifted, length checked downstream
module seep_link (
  serial_clock_in,
  link_rst_b,
  chip_sel,
  serial_in,
  frame_bits,
  bit_cnt
);
  input  wire logic                            serial_clock_in;
  input  wire logic                            link_rst_b;
  input  wire logic                            chip_sel;
  input  wire logic                            serial_in;
  output logic [seep_pkg::FRAME_BITS-1:0]      frame_bits;
  output logic [5:0]                           bit_cnt;

  logic [seep_pkg::FRAME_BITS-1:0] nxt_frame;
  logic [5:0]                      nxt_cnt;

  // leading zeros before the start bit are not counted
  always_comb begin
    nxt_frame = frame_bits;
    nxt_cnt   = bit_cnt;
    if (bit_cnt != 6'h3F && (bit_cnt != 6'h0 || serial_in)) begin
      nxt_frame = {frame_bits[seep_pkg::FRAME_BITS-2:0], serial_in};
      nxt_cnt   = bit_cnt + 6'h1;
    end
  end

  // deselect clears the shifter even with the serial clock stopped
  always_ff @(posedge serial_clock_in or negedge link_rst_b) begin
    if (!link_rst_b) begin
      frame_bits <= '0;
      bit_cnt    <= 6'h0;
    end else if (chip_sel) begin
      frame_bits <= nxt_frame;
      bit_cnt    <= nxt_cnt;
    end
  end
endmodule

/* tb/seep_prog_chk.sv */
`timescale 1ns/10ps
// ----
// status and cycle checks
// ----
module seep_prog_chk #(
  parameter int PROG_CYCLES = 2000
) (
  sys_clk,
  rst_b,
  chip_sel,
  serial_out,
  serial_out_oe,
  busy,
  prog_enabled
);
  input wire logic sys_clk;
  input wire logic rst_b;
  input wire logic chip_sel;
  input wire logic serial_out;
  input wire logic serial_out_oe;
  input wire logic busy;
  input wire logic prog_enabled;
  logic [31:0]     busy_cnt_ff;
  logic [31:0]     nxt_busy_cnt;
  always_comb begin
    nxt_busy_cnt = busy ? busy_cnt_ff + 32'h1 : 32'h0;
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_cnt_ff <= 32'h0;
    end else begin
      busy_cnt_ff <= nxt_busy_cnt;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  status_busy_a: assert property (
    busy && $past(busy) && serial_out_oe |-> !serial_out)
    else $error("ready shown while busy");
  ready_after_a: assert property (
    $fell(busy) |-> ##[0:2] serial_out) else $error("no ready");
  cycle_len_a: assert property (
    $fell(busy) |-> busy_cnt_ff == PROG_CYCLES) else $error("cycle len");
  cycle_bound_a: assert property (
    busy |-> busy_cnt_ff < PROG_CYCLES) else $error("cycle too long");
  latch_gate_a: assert property (
    $rose(busy) |-> $past(prog_enabled)) else $error("cycle while off");
  start_desel_a: assert property (
    $rose(busy) |-> !$past(chip_sel, 2)) else $error("start selected");
  latch_hold_a: assert property (
    $changed(prog_enabled) |-> !$past(busy)) else $error("latch moved");
  idle_oe_a: assert property (
    !chip_sel [*6] |-> !serial_out_oe) else $error("oe unselected");
  reset_state_a: assert property (disable iff (1'b0)
    !rst_b |-> !busy && !prog_enabled && serial_out && !serial_out_oe)
    else $error("reset state");
endmodule
bind seep_prog seep_prog_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .chip_sel(chip_sel),
  .serial_out(serial_out), .serial_out_oe(serial_out_oe),
  .busy(busy), .prog_enabled(prog_enabled));

/* tb/seep_host.sv */
`timescale 1ns/10ps
// ----
// host master: link clock runs only inside frames
// ----
module seep_host (
  serial_clock_in,
  chip_sel,
  serial_in
);
  output logic serial_clock_in;
  output logic chip_sel;
  output logic serial_in;
  initial begin
    serial_clock_in = 1'b0;
    chip_sel = 1'b0;
    serial_in = 1'b0;
  end
  task automatic frame(input logic [29:0] b, input int n);
    chip_sel = 1'b1;
    #60; // select setup: shifter leaves reset after the sync
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = b[i];
      #6 serial_clock_in = 1'b1;
      #6 serial_clock_in = 1'b0;
    end
    #3 chip_sel = 1'b0;
    serial_in = ~serial_in;
    #150;
  endtask
  task automatic sel(input logic v);
    chip_sel = v;
  endtask
endmodule

/* tb/serial_eeprom_program_erase_bench.sv */
`timescale 1ns/10ps
module serial_eeprom_program_erase_bench;
  localparam int PC = 2000;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b1;
  logic serial_clock_in, chip_sel, serial_in;
  logic serial_out, serial_out_oe, busy, prog_enabled;
  logic [9:0] rd_addr = 10'h000;
  logic [9:0] a;
  logic [15:0] rd_data, d;
  logic [15:0] lf = 16'h074B;
  logic [15:0] mem [1024];
  logic en = 1'b0;
  int fails = 0;
  int tests_run = 0;
  always #5 sys_clk = ~sys_clk;
  seep_host u_host (.serial_clock_in(serial_clock_in),
    .chip_sel(chip_sel), .serial_in(serial_in));
  seep_prog #(.PROG_CYCLES(PC)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .serial_clock_in(serial_clock_in), .chip_sel(chip_sel),
    .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .busy(busy),
    .prog_enabled(prog_enabled), .rd_addr(rd_addr), .rd_data(rd_data));
  // ----
  // helpers
  // ----
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  task automatic chk(input string nm, input logic [15:0] s, e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic results();
    if (fails == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wt(input logic v, input int n);
    for (int i = 0; i < n && busy !== v; i++) @(posedge sys_clk);
    if (busy !== v) begin
      fails++;
      results();
    end
  endtask
  task automatic chkrd(input logic [9:0] ra);
    @(posedge sys_clk);
    #1 rd_addr = ra;
    repeat (2) @(posedge sys_clk);
    #1 chk("rd_data", rd_data, mem[ra]);
  endtask
  // frames not 13 or 29 bits long, or program frames with latch clear, change nothing
  task automatic cmd(input logic [1:0] op, input logic [9:0] ca,
                     input logic [15:0] cd, input int n);
    logic ext;
    logic pg;
    logic go;
    ext = op == 2'h0;
    pg = op != 2'h2 && !(ext && ca[9] == ca[8]) && n ==
      ((op == 2'h1 || ext && ca[9:8] == 2'h1) ? 29 : 13);
    go = en && pg;
    u_host.frame({1'b0, 1'b1, op, ca, cd} >> (29 - n), n);
    if (go && op == 2'h1) mem[ca] = cd;
    if (go && op == 2'h3) mem[ca] = 16'hFFFF;
    if (go && ext) begin
      for (int i = 0; i < 1024; i++) mem[i] = ca[8] ? cd : 16'hFFFF;
    end
    if (n == 13 && ext && ca[9] == ca[8]) en = ca[9];
    u_host.sel(1'b1);
    if (go) begin
      wt(1'b1, 40);
      repeat (8) @(posedge sys_clk);
      #1 chk("oe_status", {serial_out_oe, serial_out}, 16'h2);
      wt(1'b0, PC + 40);
      repeat (3) @(posedge sys_clk);
    end else begin
      repeat (8) @(posedge sys_clk);
    end
    #1 chk("status", {serial_out_oe, busy, serial_out}, {pg, 2'h1});
    u_host.sel(1'b0);
    #150;
    chk("prog_enabled", {15'h0, prog_enabled}, {15'h0, en});
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    // a real falling edge, so the asynchronous reset fires
    #2 rst_b = 1'b0;
    repeat (6) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    cmd(2'h1, 10'h005, 16'h1234, 29);
    cmd(2'h0, 10'h300, 16'h0000, 13);
    cmd(2'h0, 10'h200, 16'h0000, 13);
    chkrd(10'h000);
    chkrd(10'h3FF);
    for (int k = 0; k < 3; k++) begin
      d = rnd();
      a = d[9:0];
      cmd(2'h1, a, ~d, 29);
      cmd(2'h1, a, rnd(), 29);
      chkrd(a);
      cmd(2'h3, a, 16'h0000, 13);
      chkrd(a);
    end
    cmd(2'h0, 10'h100, rnd(), 29);
    chkrd(a);
    cmd(2'h1, a, 16'h0000, 14);
    chkrd(a);
    cmd(2'h0, 10'h000, 16'h0000, 13);
    cmd(2'h2, a, 16'h0000, 13);
    cmd(2'h3, a, 16'h0000, 13);
    chkrd(a);
    cmd(2'h0, 10'h300, 16'h0000, 13);
    @(posedge sys_clk);
    #1 rst_b = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    en = 1'b0;
    chk("prog_enabled", {15'h0, prog_enabled}, 16'h0);
    cmd(2'h3, a, 16'h0000, 13);
    chkrd(a);
    results();
  end
endmodule
